// file: src/rc_pkg.sv
/*
 Register map, field layout, reset values and carrier types of the regulator
 control register bank. Assumes that the serial control port decodes page
 selection itself and presents functional-page accesses only.
*/
// Summary of operation
// [R1] Linear regulator B bit 7: clear means off, set means sleep on pin turn-off.
// [R2] Linear regulator B bit 6 set permits low-power; clear forbids it always.
// [R3] Linear regulator B bit 5 set turns the regulator off in standby.
// [R4] Linear regulator B bit 4 enables the regulator when set.
// [R5] Linear regulator B bits 3 to 0 select the output voltage.
// [R6] Card supply register sits at offset 0x6e, readable and writable anytime; a write in the otp load cycle after reset release is lost.
// [R7] Card supply bit 7 set means sleep on pin turn-off, clear means off.
// [R8] Card supply bit 6 set permits low-power mode, clear forbids it.
// [R9] Card supply bit 5 set switches the supply off in standby.
// [R10] Card supply bit 4 enables the card supply regulator.
// [R11] Card supply bits 1 to 0 select voltage; bits 3 to 2 reserved.
// [R12] I/O supply bit 7 set means sleep on pin turn-off, clear means off.
// [R13] I/O supply bit 6 set allows low-power mode, clear forbids it.
// [R14] I/O supply bit 5 set turns the supply off during standby.
// [R15] I/O supply bit 4 enables the I/O supply regulator.
// [R16] I/O supply bits 1 to 0 select the output voltage.
// [R17] Enable and voltage load from one-time configuration at reset; others reset zero.
// [R18] Reserved bits read as zero and ignore writes.
package rc_pkg;
   localparam logic [7:0] RC_LINB_OFFSET = 8'h6d;
   localparam logic [7:0] RC_CARD_OFFSET = 8'h6e;
   localparam logic [7:0] RC_IO_OFFSET = 8'h6f;

   localparam int RC_OFF_BEHAVIOUR_BIT = 7;
   localparam int RC_LOWPOWER_ALLOW_BIT = 6;
   localparam int RC_STANDBY_OFF_BIT = 5;
   localparam int RC_ENABLE_BIT = 4;
   localparam int RC_LINB_VSEL_W = 4;
   localparam int RC_SUPPLY_VSEL_W = 2;

   // implemented bits per register
   localparam logic [7:0] RC_LINB_MASK = 8'hff;
   localparam logic [7:0] RC_SUPPLY_MASK = 8'hf3;

   localparam logic [7:0] RC_CTRL_RESET = 8'h00;
   localparam logic [7:0] RC_READ_UNMAPPED = 8'h00;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rc_bus_req_t;

   typedef struct packed {
      logic linreg_b_enable;
      logic [RC_LINB_VSEL_W-1:0] linreg_b_voltage_sel;
      logic card_supply_enable;
      logic [RC_SUPPLY_VSEL_W-1:0] card_supply_voltage_sel;
      logic io_supply_enable;
      logic [RC_SUPPLY_VSEL_W-1:0] io_supply_voltage_sel;
   } rc_otp_cfg_t;

   typedef struct packed {
      logic on;
      logic sleep;
      logic lowpower;
   } rc_reg_state_t;
endpackage

// file: src/rc_regulator_control_regs.sv
/*
 Control registers of three regulators (linear regulator B, card supply,
 I/O supply) and the resulting per-regulator state. Assumes the serial
 control port logic runs on sys_clk_in and drives bus_in; the power-on
 request, standby and low-power request pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module rc_regulator_control_regs
   import rc_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire rc_bus_req_t bus_in,
   input wire rc_otp_cfg_t otp_cfg_in,
   input wire logic power_on_request_in,
   input wire logic standby_in,
   input wire logic lowpower_req_in,
   output var logic [7:0] rd_data_out,
   output var logic rd_valid_out,
   output var rc_reg_state_t linreg_b_state_out,
   output var rc_reg_state_t card_supply_state_out,
   output var rc_reg_state_t io_supply_state_out
);

   // regulator state from its control byte and the system conditions
   function automatic rc_reg_state_t eval_reg(input logic [7:0] ctrl, input logic pwr_off,
                                              input logic stby, input logic lp_req);
      rc_reg_state_t s;
      s = '0;
      if (!ctrl[RC_ENABLE_BIT]) begin
         s = '0;
      end else if (pwr_off) begin
         s.sleep = ctrl[RC_OFF_BEHAVIOUR_BIT];
      end else if (stby && ctrl[RC_STANDBY_OFF_BIT]) begin
         s = '0;
      end else begin
         s.on = 1'b1;
         s.lowpower = lp_req && ctrl[RC_LOWPOWER_ALLOW_BIT];
      end
      return s;
   endfunction

   // one-hot register select, zero for offsets outside the bank
   function automatic logic [2:0] decode_offset(input logic [7:0] addr);
      logic [2:0] sel;
      sel = 3'h0;
      if (addr == RC_LINB_OFFSET) begin
         sel = 3'h1;
      end else if (addr == RC_CARD_OFFSET) begin
         sel = 3'h2;
      end else if (addr == RC_IO_OFFSET) begin
         sel = 3'h4;
      end
      return sel;
   endfunction

   // pin synchronisers
   logic [1:0] pwr_sync, stby_sync, lp_sync;
   logic [1:0] next_pwr_sync, next_stby_sync, next_lp_sync;

   always_comb begin
      next_pwr_sync = {pwr_sync[0], power_on_request_in};
      next_stby_sync = {stby_sync[0], standby_in};
      next_lp_sync = {lp_sync[0], lowpower_req_in};
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pwr_sync <= 2'h0;
         stby_sync <= 2'h0;
         lp_sync <= 2'h0;
      end else begin
         pwr_sync <= next_pwr_sync;
         stby_sync <= next_stby_sync;
         lp_sync <= next_lp_sync;
      end
   end

   // control registers
   logic [7:0] linb_ctrl, card_ctrl, io_ctrl;
   logic [7:0] next_linb_ctrl, next_card_ctrl, next_io_ctrl;
   logic otp_done, next_otp_done;
   // one decode shared by the write and read paths
   logic [2:0] bus_sel;

   always_comb begin
      bus_sel = decode_offset(bus_in.addr);
   end

   always_comb begin
      next_linb_ctrl = linb_ctrl;
      next_card_ctrl = card_ctrl;
      next_io_ctrl = io_ctrl;
      next_otp_done = 1'b1;
      if (!otp_done) begin
         // otp is caught once after reset release, never through the async reset
         next_linb_ctrl = {3'h0, otp_cfg_in.linreg_b_enable,
                           otp_cfg_in.linreg_b_voltage_sel}; // R17
         next_card_ctrl = {3'h0, otp_cfg_in.card_supply_enable, 2'h0,
                           otp_cfg_in.card_supply_voltage_sel}; // R17
         next_io_ctrl = {3'h0, otp_cfg_in.io_supply_enable, 2'h0,
                         otp_cfg_in.io_supply_voltage_sel}; // R17
      end else if (bus_in.wr) begin
         if (bus_sel[0]) begin
            next_linb_ctrl = bus_in.wdata & RC_LINB_MASK; // R5
         end else if (bus_sel[1]) begin
            next_card_ctrl = bus_in.wdata & RC_SUPPLY_MASK; // R6 R11 R18
         end else if (bus_sel[2]) begin
            next_io_ctrl = bus_in.wdata & RC_SUPPLY_MASK; // R16 R18
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         linb_ctrl <= RC_CTRL_RESET;
         card_ctrl <= RC_CTRL_RESET;
         io_ctrl <= RC_CTRL_RESET;
         otp_done <= 1'b0;
      end else begin
         linb_ctrl <= next_linb_ctrl;
         card_ctrl <= next_card_ctrl;
         io_ctrl <= next_io_ctrl;
         otp_done <= next_otp_done;
      end
   end

   // read port; a read in the same cycle as a write returns the old value
   logic [7:0] next_rd_data;
   logic next_rd_valid;

   always_comb begin
      next_rd_valid = bus_in.rd;
      next_rd_data = RC_READ_UNMAPPED;
      if (!bus_in.rd) begin
         next_rd_data = RC_READ_UNMAPPED;
      end else if (bus_sel[0]) begin
         next_rd_data = linb_ctrl;
      end else if (bus_sel[1]) begin
         next_rd_data = card_ctrl; // R6
      end else if (bus_sel[2]) begin
         next_rd_data = io_ctrl;
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_data_out <= RC_READ_UNMAPPED;
         rd_valid_out <= 1'b0;
      end else begin
         rd_data_out <= next_rd_data;
         rd_valid_out <= next_rd_valid;
      end
   end

   // regulator state; pin low is the turn-off event condition
   rc_reg_state_t next_linb_state, next_card_state, next_io_state;

   always_comb begin
      next_linb_state = eval_reg(linb_ctrl, !pwr_sync[1], stby_sync[1], lp_sync[1]); // R1 R2 R3 R4
      next_card_state = eval_reg(card_ctrl, !pwr_sync[1], stby_sync[1], lp_sync[1]); // R7 R8 R9 R10
      next_io_state = eval_reg(io_ctrl, !pwr_sync[1], stby_sync[1], lp_sync[1]); // R12 R13 R14 R15
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         linreg_b_state_out <= '0;
         card_supply_state_out <= '0;
         io_supply_state_out <= '0;
      end else begin
         linreg_b_state_out <= next_linb_state;
         card_supply_state_out <= next_card_state;
         io_supply_state_out <= next_io_state;
      end
   end

   // checks
   sequence s_linb_write;
      otp_done && bus_in.wr && bus_in.addr == RC_LINB_OFFSET;
   endsequence

   sequence s_read_after(logic [7:0] a);
      !bus_in.wr && bus_in.rd && bus_in.addr == a;
   endsequence

   sequence s_io_write;
      otp_done && bus_in.wr && bus_in.addr == RC_IO_OFFSET;
   endsequence

   sequence s_unmapped_read;
      bus_in.rd && bus_in.addr != RC_LINB_OFFSET && bus_in.addr != RC_CARD_OFFSET
         && bus_in.addr != RC_IO_OFFSET;
   endsequence

   sequence s_unmapped_write;
      otp_done && bus_in.wr && bus_in.addr != RC_LINB_OFFSET
         && bus_in.addr != RC_CARD_OFFSET && bus_in.addr != RC_IO_OFFSET;
   endsequence

   // enabled regulator seeing a pin turn-off
   sequence s_off_event(logic [7:0] ctrl);
      ctrl[RC_ENABLE_BIT] && !pwr_sync[1];
   endsequence

   sequence s_standby_event(logic [7:0] ctrl);
      ctrl[RC_ENABLE_BIT] && pwr_sync[1] && stby_sync[1];
   endsequence

   // enabled, powered and not parked by standby
   sequence s_running(logic [7:0] ctrl);
      ctrl[RC_ENABLE_BIT] && pwr_sync[1] && !(stby_sync[1] && ctrl[RC_STANDBY_OFF_BIT]);
   endsequence

   a_linb_off_sleep: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R1
      (linb_ctrl[RC_ENABLE_BIT] && !pwr_sync[1])
      |=> (linreg_b_state_out.sleep == $past(linb_ctrl[RC_OFF_BEHAVIOUR_BIT])
           && !linreg_b_state_out.on))
      else $error("linear b turn-off behaviour wrong");

   a_linb_lowpower_gate: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R2
      !linb_ctrl[RC_LOWPOWER_ALLOW_BIT] |=> !linreg_b_state_out.lowpower)
      else $error("linear b entered low power while forbidden");

   a_linb_standby_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R3
      (pwr_sync[1] && stby_sync[1] && linb_ctrl[RC_ENABLE_BIT])
      |=> linreg_b_state_out.on == !$past(linb_ctrl[RC_STANDBY_OFF_BIT]))
      else $error("linear b standby handling wrong");

   a_linb_enable_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R4
      !linb_ctrl[RC_ENABLE_BIT] |=> linreg_b_state_out == '0)
      else $error("disabled linear b not off");

   a_linb_write_read: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R5
      s_linb_write ##1 !bus_in.wr ##1 s_read_after(RC_LINB_OFFSET)
      |=> rd_valid_out && rd_data_out == $past(bus_in.wdata, 3))
      else $error("linear b readback mismatch");

   a_card_write_read: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R6
      (otp_done && bus_in.wr && bus_in.addr == RC_CARD_OFFSET) ##1 !bus_in.wr
      ##1 s_read_after(RC_CARD_OFFSET)
      |=> rd_data_out == ($past(bus_in.wdata, 3) & RC_SUPPLY_MASK))
      else $error("card supply readback mismatch");

   a_card_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R11
      (bus_in.rd && bus_in.addr == RC_CARD_OFFSET) |=> rd_data_out[3:2] == 2'h0)
      else $error("card supply reserved bits not zero");

   a_io_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R18
      (bus_in.rd && bus_in.addr == RC_IO_OFFSET) |=> rd_data_out[3:2] == 2'h0)
      else $error("io supply reserved bits not zero");

   a_io_enable_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R15
      !io_ctrl[RC_ENABLE_BIT] |=> io_supply_state_out == '0)
      else $error("disabled io supply not off");

   a_otp_load: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R17
      !otp_done |=> (linb_ctrl[7:5] == 3'h0 && card_ctrl[7:5] == 3'h0
                     && linb_ctrl[RC_ENABLE_BIT] == $past(otp_cfg_in.linreg_b_enable)
                     && io_ctrl[1:0] == $past(otp_cfg_in.io_supply_voltage_sel)))
      else $error("otp defaults not loaded");

   a_otp_supply_load: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R17
      !otp_done |=> (io_ctrl[7:5] == 3'h0
                     && card_ctrl[RC_ENABLE_BIT] == $past(otp_cfg_in.card_supply_enable)
                     && card_ctrl[1:0] == $past(otp_cfg_in.card_supply_voltage_sel)
                     && io_ctrl[RC_ENABLE_BIT] == $past(otp_cfg_in.io_supply_enable)
                     && linb_ctrl[3:0] == $past(otp_cfg_in.linreg_b_voltage_sel)))
      else $error("supply otp defaults not loaded");

   a_linb_running: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R2
      s_running(linb_ctrl)
      |=> (linreg_b_state_out.on && !linreg_b_state_out.sleep
           && linreg_b_state_out.lowpower == ($past(lp_sync[1])
                                              && $past(linb_ctrl[RC_LOWPOWER_ALLOW_BIT]))))
      else $error("running linear b state wrong");

   a_card_off_sleep: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R7
      s_off_event(card_ctrl)
      |=> (card_supply_state_out.sleep == $past(card_ctrl[RC_OFF_BEHAVIOUR_BIT])
           && !card_supply_state_out.on && !card_supply_state_out.lowpower))
      else $error("card supply turn-off behaviour wrong");

   a_card_lowpower_gate: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R8
      !card_ctrl[RC_LOWPOWER_ALLOW_BIT] |=> !card_supply_state_out.lowpower)
      else $error("card supply entered low power while forbidden");

   a_card_standby_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R9
      s_standby_event(card_ctrl)
      |=> card_supply_state_out.on == !$past(card_ctrl[RC_STANDBY_OFF_BIT]))
      else $error("card supply standby handling wrong");

   a_card_enable_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R10
      !card_ctrl[RC_ENABLE_BIT] |=> card_supply_state_out == '0)
      else $error("disabled card supply not off");

   a_card_running: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R10
      s_running(card_ctrl)
      |=> (card_supply_state_out.on && !card_supply_state_out.sleep
           && card_supply_state_out.lowpower == ($past(lp_sync[1])
                                                 && $past(card_ctrl[RC_LOWPOWER_ALLOW_BIT]))))
      else $error("running card supply state wrong");

   a_io_off_sleep: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R12
      s_off_event(io_ctrl)
      |=> (io_supply_state_out.sleep == $past(io_ctrl[RC_OFF_BEHAVIOUR_BIT])
           && !io_supply_state_out.on && !io_supply_state_out.lowpower))
      else $error("io supply turn-off behaviour wrong");

   a_io_lowpower_gate: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R13
      !io_ctrl[RC_LOWPOWER_ALLOW_BIT] |=> !io_supply_state_out.lowpower)
      else $error("io supply entered low power while forbidden");

   a_io_standby_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R14
      s_standby_event(io_ctrl)
      |=> io_supply_state_out.on == !$past(io_ctrl[RC_STANDBY_OFF_BIT]))
      else $error("io supply standby handling wrong");

   a_io_running: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R15
      s_running(io_ctrl)
      |=> (io_supply_state_out.on && !io_supply_state_out.sleep
           && io_supply_state_out.lowpower == ($past(lp_sync[1])
                                               && $past(io_ctrl[RC_LOWPOWER_ALLOW_BIT]))))
      else $error("running io supply state wrong");

   a_io_write_read: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R16
      s_io_write ##1 !bus_in.wr ##1 s_read_after(RC_IO_OFFSET)
      |=> rd_data_out == ($past(bus_in.wdata, 3) & RC_SUPPLY_MASK))
      else $error("io supply readback mismatch");

   a_read_pulse: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R6
      bus_in.rd |=> rd_valid_out)
      else $error("read not answered");

   a_idle_read_zero: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R18
      !bus_in.rd |=> (!rd_valid_out && rd_data_out == RC_READ_UNMAPPED))
      else $error("read port not idle");

   a_unmapped_read: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R18
      s_unmapped_read |=> (rd_valid_out && rd_data_out == RC_READ_UNMAPPED))
      else $error("unmapped read not zero");

   a_unmapped_write: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R18
      s_unmapped_write |=> ($stable(linb_ctrl) && $stable(card_ctrl) && $stable(io_ctrl)))
      else $error("unmapped write changed a register");

   a_reserved_kept: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R11
      (card_ctrl[3:2] == 2'h0 && io_ctrl[3:2] == 2'h0))
      else $error("reserved control bits set");

   a_ctrl_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R6
      (otp_done && !bus_in.wr) |=> ($stable(linb_ctrl) && $stable(card_ctrl) && $stable(io_ctrl)))
      else $error("control register changed without a write");

endmodule // rc_regulator_control_regs
`default_nettype wire

// file: sim/rc_regulator_control_regs_tb.sv
/*
 Self-checking bench of the regulator control register bank: reset values,
 register access with reserved bits and unmapped offsets, regulator states.
 Assumes the bank sits behind the serial control port's internal strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module rc_regulator_control_regs_tb;
   import rc_pkg::*;
   logic sys_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   rc_bus_req_t bus_in = '0;
   rc_otp_cfg_t otp_cfg_in = '0;
   logic power_on_request_in = 1'b1;
   logic standby_in = 1'b0;
   logic lowpower_req_in = 1'b0;
   logic [7:0] rd_data_out;
   logic rd_valid_out;
   rc_reg_state_t linreg_b_state_out;
   rc_reg_state_t card_supply_state_out;
   rc_reg_state_t io_supply_state_out;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h10;
   logic [7:0] shadow [3];

   always #10 sys_clk_in = ~sys_clk_in;

   rc_regulator_control_regs i_dut (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .bus_in(bus_in),
      .otp_cfg_in(otp_cfg_in),
      .power_on_request_in(power_on_request_in),
      .standby_in(standby_in),
      .lowpower_req_in(lowpower_req_in),
      .rd_data_out(rd_data_out),
      .rd_valid_out(rd_valid_out),
      .linreg_b_state_out(linreg_b_state_out),
      .card_supply_state_out(card_supply_state_out),
      .io_supply_state_out(io_supply_state_out)
   );

   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [7:0] mask_of(input logic [7:0] a);
      if (a == RC_LINB_OFFSET) return RC_LINB_MASK;
      if (a == RC_CARD_OFFSET || a == RC_IO_OFFSET) return RC_SUPPLY_MASK;
      return 8'h00;
   endfunction

   // priority: disabled, turn-off, standby, normal
   function automatic logic [7:0] exp_state(input logic [7:0] c);
      if (!c[4]) return 8'h00;
      if (!power_on_request_in) return {6'h00, c[7], 1'b0};
      if (standby_in && c[5]) return 8'h00;
      return {5'h00, 1'b1, 1'b0, lowpower_req_in & c[6]};
   endfunction

   task automatic end_of_test();
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_in);
      bus_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk_in);
      bus_in = '0;
      if (mask_of(a) != 8'h00)
         shadow[a - 8'h6d] = d & mask_of(a);
   endtask

   // read data stands one cycle only, so look at the next falling edge
   task automatic rd_chk(input logic [7:0] a, input string what);
      @(negedge sys_clk_in);
      bus_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge sys_clk_in);
      bus_in = '0;
      chk({7'h00, rd_valid_out}, 8'h01, "read valid");
      chk(rd_data_out, (mask_of(a) != 8'h00) ? shadow[a - 8'h6d] : 8'h00, what);
   endtask

   initial begin
      logic [31:0] r;
      logic [7:0] a;
      r = next_rand();
      otp_cfg_in = r[$bits(rc_otp_cfg_t)-1:0];
      repeat (6) @(posedge sys_clk_in);
      @(negedge sys_clk_in) reset_n_in = 1'b1;
      @(negedge sys_clk_in);
      shadow[0] = {3'b000, otp_cfg_in.linreg_b_enable, otp_cfg_in.linreg_b_voltage_sel};
      shadow[1] = {3'b000, otp_cfg_in.card_supply_enable, 2'b00,
                   otp_cfg_in.card_supply_voltage_sel};
      shadow[2] = {3'b000, otp_cfg_in.io_supply_enable, 2'b00, otp_cfg_in.io_supply_voltage_sel};
      for (int i = 0; i < 3; i++) rd_chk(8'h6d + 8'(i), "reset value");
      $display("test reset values done");
      // corners first: all ones and all zeros, neighbours of the map included
      for (int i = 0; i < 10; i++) begin
         a = 8'h6c + 8'(i % 5);
         wr_reg(a, (i < 5) ? 8'hff : 8'h00);
         rd_chk(a, "corner access");
      end
      for (int i = 0; i < 60; i++) begin
         r = next_rand();
         a = (r[1:0] == 2'b11) ? r[15:8] : 8'h6d + {6'h00, r[1:0]};
         wr_reg(a, r[23:16]);
         rd_chk(a, "random access");
      end
      for (int i = 0; i < 3; i++) rd_chk(8'h6d + 8'(i), "after unmapped");
      $display("test register access done");
      for (int i = 0; i < 40; i++) begin
         for (int k = 0; k < 3; k++) begin
            r = next_rand();
            wr_reg(8'h6d + 8'(k), r[7:0]);
         end
         r = next_rand();
         power_on_request_in = r[0] | r[1];
         standby_in = r[2];
         lowpower_req_in = r[3];
         // two sync stages plus output register, with margin
         repeat (5) @(negedge sys_clk_in);
         chk({5'h00, linreg_b_state_out}, exp_state(shadow[0]), "linb state");
         chk({5'h00, card_supply_state_out}, exp_state(shadow[1]), "card state");
         chk({5'h00, io_supply_state_out}, exp_state(shadow[2]), "io state");
      end
      $display("test regulator states done");
      end_of_test();
   end
endmodule // rc_regulator_control_regs_tb
`default_nettype wire
